// ### shared/pidl_pkg.sv
// Constants, types and helpers shared by the PID motor loop
package pidl_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned PERIOD_MS = 16;
    localparam int unsigned PERIOD_CYC = CLK_HZ / 1000 * PERIOD_MS;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_GAIN = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_PWR = 8'h10;
    localparam logic [7:0] REG_MEAS = 8'h14;
    localparam int CTRL_ENC_BIT = 2;
    localparam int GAIN_KP_LSB = 0;
    localparam int GAIN_KI_LSB = 8;
    localparam int GAIN_KD_LSB = 16;
    localparam int CMD_B_LSB = 8;
    localparam int STAT_ENC_BIT = 1;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [23:0] GAIN_RST = 24'h000001;
    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam int INT_W = 16;
    localparam logic signed [15:0] INT_MAX = 16'sh0fff;
    localparam logic signed [15:0] INT_MIN = -16'sh0fff;
    localparam int INT_SHIFT = 4;
    localparam logic signed [7:0] PWR_QTR = 8'sh20;
    localparam logic [8:0] RAW_MID = 9'h080;

    typedef enum logic [1:0] {MODE_POS, MODE_SPD_SEP, MODE_SPD_MIX, MODE_SPD_POS} pidl_mode_t;
    typedef logic signed [7:0] pidl_pwr_t;
    typedef logic [7:0] pidl_raw_t;

    // Clip a wide signed value to the symmetric +-127 power range
    function automatic pidl_pwr_t pidl_sat(input logic signed [31:0] v);
        if (v > 32'sh7f) return 8'sh7f;
        if (v < -32'sh7f) return 8'sh81;
        return v[7:0];
    endfunction

    // Unsigned analog code to signed reading, mid-scale is zero
    function automatic pidl_pwr_t pidl_conv(input pidl_raw_t raw);
        logic signed [8:0] d;
        d = $signed({1'b0, raw}) - $signed(RAW_MID);
        if (d < -9'sh07f) return 8'sh81;
        return d[7:0];
    endfunction

    // Magnitude of a power value
    function automatic pidl_pwr_t pidl_mag(input pidl_pwr_t p);
        return (p < 0) ? 8'(-p) : p;
    endfunction
endpackage

// ### shared/pidl_pid_if.sv
// Operand and result bundle between the loop controller and one PID channel
`timescale 1ns/1ps
interface pidl_pid_if;
    import pidl_pkg::*;
    logic step;
    logic halt;
    logic [7:0] kp;
    logic [7:0] ki;
    logic [7:0] kd;
    pidl_pwr_t sp;
    pidl_pwr_t meas;
    pidl_pwr_t pwr;
    modport ctl(output step, halt, kp, ki, kd, sp, meas, input pwr);
    modport pid(input step, halt, kp, ki, kd, sp, meas, output pwr);
endinterface

// ### rtl/pidl_tick.sv
// Control period divider: one-cycle enable pulse every period
`timescale 1ns/1ps
module pidl_tick #(
    parameter int unsigned CYC = pidl_pkg::PERIOD_CYC
) (
    input wire logic clk_i, // Controller clock
    input wire logic nrst_i, // Async reset, active low
    output logic tick_o // Period pulse
);
    import pidl_pkg::*;
    localparam int CW = $clog2(CYC + 1);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic tick_nxt;
    logic [CW-1:0] gap_r;
    logic seen_r;

    // Count down one period, pulse on wrap
    always_comb begin
        tick_nxt = (cnt_r == '0);
        cnt_nxt = (cnt_r == '0) ? CW'(CYC - 1) : cnt_r - 1'b1;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_o <= tick_nxt;
        end
    end

    // Helper for the spacing check only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_r <= '0;
            seen_r <= 1'b0;
        end else begin
            gap_r <= tick_o ? '0 : gap_r + 1'b1;
            seen_r <= seen_r | tick_o;
        end
    end

    a_tick_spacing: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tick_o && seen_r |-> gap_r == CW'(CYC - 1))
        else $error("Period pulse spacing wrong");
endmodule

// ### rtl/pidl_pid.sv
// One PID channel: error, integral, derivative and saturated power
`timescale 1ns/1ps
module pidl_pid (
    input wire logic clk_i, // Controller clock
    input wire logic nrst_i, // Async reset, active low
    pidl_pid_if.pid pif // Operands in, power out
);
    import pidl_pkg::*;
    logic signed [8:0] err_r, err_nxt;
    logic signed [INT_W-1:0] integ_r, integ_nxt;
    pidl_pwr_t pwr_r, pwr_nxt;
    logic signed [31:0] acc, sum;

    // New terms are formed only on the period step; halt forces zero power
    always_comb begin
        err_nxt = err_r;
        integ_nxt = integ_r;
        pwr_nxt = pwr_r;
        acc = '0;
        sum = '0;
        if (pif.halt) begin
            pwr_nxt = '0;
            integ_nxt = '0;
        end else if (pif.step) begin
            err_nxt = 9'(pif.sp) - 9'(pif.meas);
            acc = 32'(integ_r) + 32'(err_nxt);
            if (acc > 32'(INT_MAX)) acc = 32'(INT_MAX);
            else if (acc < 32'(INT_MIN)) acc = 32'(INT_MIN);
            integ_nxt = acc[INT_W-1:0];
            sum = $signed({24'h000000, pif.kp}) * 32'(err_nxt)
                + $signed({24'h000000, pif.kd}) * (32'(err_nxt) - 32'(err_r))
                + (($signed({24'h000000, pif.ki}) * 32'(integ_nxt)) >>> INT_SHIFT);
            pwr_nxt = pidl_sat(sum);
        end
    end

    // Previous error is kept for the derivative across periods
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            err_r <= '0;
            integ_r <= '0;
            pwr_r <= '0;
        end else begin
            err_r <= err_nxt;
            integ_r <= integ_nxt;
            pwr_r <= pwr_nxt;
        end
    end
    assign pif.pwr = pwr_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_power_sat: assert property (pwr_r <= 8'sh7f && pwr_r >= 8'sh81)
        else $error("Power outside full scale");
    a_prop_only: assert property (pif.step && !pif.halt && pif.ki == 8'h00 && pif.kd == 8'h00
        |=> pwr_r == pidl_sat(32'($past(err_nxt)) * $signed({24'h000000, $past(pif.kp)})))
        else $error("Power not error times gain");
    a_zero_power: assert property (pif.step && !pif.halt && pif.ki == 8'h00
        && pif.sp == pif.meas && err_r == 9'sh000 |=> pwr_r == 8'sh00)
        else $error("Power not zero when settled");
    a_integ_bound: assert property (integ_r <= INT_MAX && integ_r >= INT_MIN)
        else $error("Integral out of bounds");
    a_diff_hold: assert property (!pif.step && !pif.halt |=> $stable(err_r) && $stable(pwr_r))
        else $error("Loop state moved between periods");
endmodule

// ### rtl/pidl_loop.sv
// Two-channel PID position and speed regulator with APB registers
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module pidl_loop #(
    parameter int unsigned PERIOD_CYCLES = pidl_pkg::PERIOD_CYC
) (
    input wire logic REF_CLK_I, // Controller clock, 100 MHz
    input wire logic NRST_I, // Async reset, active low
    input wire logic PSEL_I, // APB select
    input wire logic PENABLE_I, // APB enable
    input wire logic PWRITE_I, // APB write
    input wire logic [7:0] PADDR_I, // APB byte address
    input wire logic [31:0] PWDATA_I, // APB write data
    output logic [31:0] PRDATA_O, // APB read data
    output logic PREADY_O, // APB ready
    output logic PSLVERR_O, // APB error on unmapped address
    input wire pidl_pkg::pidl_raw_t ANA_A_I, // Channel A analog sensor code
    input wire pidl_pkg::pidl_raw_t ANA_B_I, // Channel B analog sensor code
    input wire logic ENC_PRESENT_I, // Encoder module fitted strap
    input wire pidl_pkg::pidl_pwr_t ENC_SPD_A_I, // Channel A encoder speed
    input wire pidl_pkg::pidl_pwr_t ENC_SPD_B_I, // Channel B encoder speed
    input wire logic [1:0] ENC_MOVE_I, // Encoder motion pulses, bit 0 is A
    output pidl_pkg::pidl_pwr_t PWR_A_O, // Channel A applied power
    output pidl_pkg::pidl_pwr_t PWR_B_O, // Channel B applied power
    output logic HALT_O // Permanent encoder fault halt
);
    import pidl_pkg::*;

    logic [2:0] ctrl_r, ctrl_nxt;
    logic [23:0] gain_r, gain_nxt;
    logic [15:0] cmd_r, cmd_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt;
    logic setup, access_wr, mapped;
    logic strap_done_r, enc_fitted_r, enc_fitted_nxt;
    logic halt_r, halt_nxt;
    logic [1:0] motion_r, motion_nxt;
    logic [1:0] stall;
    logic step;
    pidl_mode_t mode;
    logic spd_a, spd_b, mix, use_enc;
    pidl_pwr_t cmd_a, cmd_b, ana_a, ana_b;
    pidl_pid_if pif_a();
    pidl_pid_if pif_b();

    // Period enable for both channels
    pidl_tick #(.CYC(PERIOD_CYCLES)) u_tick (
        .clk_i(REF_CLK_I),
        .nrst_i(NRST_I),
        .tick_o(step)
    );

    // Bus phase decode; register data is latched in setup so access finishes at once
    assign setup = PSEL_I && !PENABLE_I;
    assign access_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;
    assign mapped = (PADDR_I == REG_CTRL) || (PADDR_I == REG_GAIN) || (PADDR_I == REG_CMD)
        || (PADDR_I == REG_STAT) || (PADDR_I == REG_PWR) || (PADDR_I == REG_MEAS);

    // Register writes and read data; status and power are read only
    always_comb begin
        ctrl_nxt = ctrl_r;
        gain_nxt = gain_r;
        cmd_nxt = cmd_r;
        prdata_nxt = PRDATA_O;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (setup) begin
            pready_nxt = 1'b1;
            pslverr_nxt = !mapped;
            case (PADDR_I)
                REG_CTRL: prdata_nxt = {29'h00000000, ctrl_r};
                REG_GAIN: prdata_nxt = {8'h00, gain_r};
                REG_CMD: prdata_nxt = {16'h0000, cmd_r};
                REG_STAT: prdata_nxt = {30'h00000000, enc_fitted_r, halt_r};
                REG_PWR: prdata_nxt = {16'h0000, PWR_B_O, PWR_A_O};
                REG_MEAS: prdata_nxt = {16'h0000, pif_b.meas, pif_a.meas};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
        if (access_wr) begin
            case (PADDR_I)
                REG_CTRL: ctrl_nxt = PWDATA_I[2:0];
                REG_GAIN: gain_nxt = PWDATA_I[23:0];
                REG_CMD: cmd_nxt = PWDATA_I[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl_r <= CTRL_RST;
            gain_r <= GAIN_RST;
            cmd_r <= CMD_RST;
            PRDATA_O <= 32'h00000000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            gain_r <= gain_nxt;
            cmd_r <= cmd_nxt;
            PRDATA_O <= prdata_nxt;
            PREADY_O <= pready_nxt;
            PSLVERR_O <= pslverr_nxt;
        end
    end

    // Encoder strap is caught on the first clock after reset release
    always_comb begin
        enc_fitted_nxt = strap_done_r ? enc_fitted_r : ENC_PRESENT_I;
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            strap_done_r <= 1'b0;
            enc_fitted_r <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;
            enc_fitted_r <= enc_fitted_nxt;
        end
    end

    // Mode decode: which channel runs the speed loop, and whether commands mix
    assign mode = pidl_mode_t'(ctrl_r[1:0]);
    assign spd_a = (mode != MODE_POS);
    assign spd_b = (mode == MODE_SPD_SEP) || (mode == MODE_SPD_MIX);
    assign mix = (mode == MODE_SPD_MIX);
    assign use_enc = enc_fitted_r && ctrl_r[CTRL_ENC_BIT];
    assign cmd_a = cmd_r[7:0];
    assign cmd_b = cmd_r[CMD_B_LSB+7:CMD_B_LSB];

    // Analog codes become signed readings; sensor polarity is the wiring's job
    assign ana_a = pidl_conv(ANA_A_I);
    assign ana_b = pidl_conv(ANA_B_I);

    // Setpoints: mixed mode turns throttle and steering into per-side speeds
    assign pif_a.sp = mix ? pidl_sat(32'(cmd_a) + 32'(cmd_b)) : cmd_a;
    assign pif_b.sp = mix ? pidl_sat(32'(cmd_a) - 32'(cmd_b)) : cmd_b;

    // Measure: speed channels may take encoder speed, position always analog
    assign pif_a.meas = (spd_a && use_enc) ? ENC_SPD_A_I : ana_a;
    assign pif_b.meas = (spd_b && use_enc) ? ENC_SPD_B_I : ana_b;

    // One gain set drives both channels
    assign pif_a.kp = gain_r[GAIN_KP_LSB+7:GAIN_KP_LSB];
    assign pif_a.ki = gain_r[GAIN_KI_LSB+7:GAIN_KI_LSB];
    assign pif_a.kd = gain_r[GAIN_KD_LSB+7:GAIN_KD_LSB];
    assign pif_b.kp = pif_a.kp;
    assign pif_b.ki = pif_a.ki;
    assign pif_b.kd = pif_a.kd;
    assign pif_a.step = step;
    assign pif_b.step = step;
    assign pif_a.halt = halt_r;
    assign pif_b.halt = halt_r;

    pidl_pid u_pid_a (
        .clk_i(REF_CLK_I),
        .nrst_i(NRST_I),
        .pif(pif_a.pid)
    );

    pidl_pid u_pid_b (
        .clk_i(REF_CLK_I),
        .nrst_i(NRST_I),
        .pif(pif_b.pid)
    );

    assign PWR_A_O = pif_a.pwr;
    assign PWR_B_O = pif_b.pwr;

    // A channel stalls if its encoder saw no motion during a period at quarter power
    assign stall[0] = spd_a && use_enc && !motion_r[0] && (pidl_mag(PWR_A_O) >= PWR_QTR);
    assign stall[1] = spd_b && use_enc && !motion_r[1] && (pidl_mag(PWR_B_O) >= PWR_QTR);

    // Motion flags clear each period; a pulse in the clearing cycle still counts
    always_comb begin
        motion_nxt = step ? ENC_MOVE_I : (motion_r | ENC_MOVE_I);
        halt_nxt = halt_r || (step && (stall != 2'b00));
    end

    // Halt is sticky; only reset releases it
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            motion_r <= 2'b00;
            halt_r <= 1'b0;
        end else begin
            motion_r <= motion_nxt;
            halt_r <= halt_nxt;
        end
    end
    assign HALT_O = halt_r;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence s_answer;
        PREADY_O ##1 !PREADY_O;
    endsequence
    property p_zero_wait;
        s_setup |=> s_answer;
    endproperty

    a_apb_zero_wait: assert property (p_zero_wait)
        else $error("APB answer not in first access cycle");
    a_halt_sticky: assert property (halt_r |=> halt_r)
        else $error("Halt released without reset");
    a_halt_cause: assert property ($rose(halt_r) |-> $past(step) && $past(stall) != 2'b00)
        else $error("Halt without stalled encoder");
    a_halt_power: assert property (halt_r |=> PWR_A_O == 8'sh00 && PWR_B_O == 8'sh00)
        else $error("Power applied while halted");
    a_mix_setpoint: assert property (mode == MODE_SPD_MIX
        |-> pif_a.sp == pidl_sat(32'(cmd_a) + 32'(cmd_b)) && pif_b.sp == pidl_sat(32'(cmd_a) - 32'(cmd_b)))
        else $error("Mixed setpoints wrong");
    a_split_pos: assert property (mode == MODE_SPD_POS |-> pif_b.meas == ana_b && pif_b.sp == cmd_b)
        else $error("Channel B not on position loop");
    a_enc_select: assert property (!enc_fitted_r |-> pif_a.meas == ana_a && pif_b.meas == ana_b)
        else $error("Encoder used while not fitted");
endmodule

// ### test/pidl_motor_model.sv
// Behavioural motor, power stage and encoder on the far side of the loop
`timescale 1ns/1ps
module pidl_motor_model (
    input wire logic clk_i, // Controller clock
    input wire pidl_pkg::pidl_pwr_t pwr_a_i, // Applied power, channel A
    input wire pidl_pkg::pidl_pwr_t pwr_b_i, // Applied power, channel B
    input wire logic stall_i, // Shafts locked by the bench
    input wire pidl_pkg::pidl_pwr_t spd_i, // Speed magnitude while turning
    output pidl_pkg::pidl_pwr_t enc_spd_a_o, // Encoder speed, channel A
    output pidl_pkg::pidl_pwr_t enc_spd_b_o, // Encoder speed, channel B
    output logic [1:0] enc_move_o // Encoder motion pulses
);
    import pidl_pkg::*;
    logic ph_r = 1'b0;
    logic spin_a;
    logic spin_b;

    // A shaft turns only while driven and not locked
    assign spin_a = (pwr_a_i != 8'sh00) && !stall_i;
    assign spin_b = (pwr_b_i != 8'sh00) && !stall_i;

    // Motion comes as pulses on alternate cycles, not as a steady level
    always @(posedge clk_i) begin
        ph_r <= ~ph_r;
    end
    assign enc_move_o = {spin_b & ph_r, spin_a & ph_r};

    // Stopped shaft reads zero; direction follows the sign of the drive
    assign enc_spd_a_o = !spin_a ? 8'sh00 : (pwr_a_i[7] ? -spd_i : spd_i);
    assign enc_spd_b_o = !spin_b ? 8'sh00 : (pwr_b_i[7] ? -spd_i : spd_i);
endmodule

// ### test/pidl_loop_bench.sv
// Self-checking bench for the two-channel PID loop
`timescale 1ns/1ps
module pidl_loop_bench;
    import pidl_pkg::*;
    localparam int P = 50;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, halt, err;
    logic stall = 1'b0;
    logic fitted = 1'b1; // Encoder module strap, dropped before the last reset
    pidl_raw_t ana_a = 8'h80;
    pidl_raw_t ana_b = 8'h80;
    pidl_pwr_t pa, pb, esa, esb;
    pidl_pwr_t spd = 8'sh14;
    logic [1:0] move;
    int miscompares = 0;
    int comparisons = 0;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    pidl_loop #(.PERIOD_CYCLES(P)) dut_u (.REF_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .ANA_A_I(ana_a), .ANA_B_I(ana_b), .ENC_PRESENT_I(fitted), .ENC_SPD_A_I(esa),
        .ENC_SPD_B_I(esb), .ENC_MOVE_I(move), .PWR_A_O(pa), .PWR_B_O(pb), .HALT_O(halt));

    pidl_motor_model motor_u (.clk_i(clk), .pwr_a_i(pa), .pwr_b_i(pb), .stall_i(stall), .spd_i(spd),
        .enc_spd_a_o(esa), .enc_spd_b_o(esb), .enc_move_o(move));

    task close_out;
        if (miscompares == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Sensor code for a signed reading, mid-scale is zero
    function automatic pidl_raw_t code(input int m);
        return 8'(128 + m);
    endfunction

    // One APB transfer; an idle edge first keeps back-to-back calls race free
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 20 && pready !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: bus never ready", $time);
            close_out();
        end
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, experr});
    endtask

    // Waits a bounded time for a channel's power to reach a value
    task wait_pwr(input logic b, input pidl_pwr_t e, input int lim);
        int n;
        n = 0;
        while ((b ? pb : pa) !== e && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk({24'h0, b ? pb : pa}, {24'h0, e});
        if ((b ? pb : pa) !== e)
            close_out();
    endtask

    task do_reset;
        nrst <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk({23'h0, halt, pa}, 32'h0);
    endtask

    task s_regs;
        rd_chk(REG_CTRL, {29'h0, CTRL_RST}, 1'b0);
        rd_chk(REG_GAIN, {8'h0, GAIN_RST}, 1'b0);
        rd_chk(REG_CMD, {16'h0, CMD_RST}, 1'b0);
        rd_chk(REG_STAT, 32'h2, 1'b0);
        apb(1'b1, REG_STAT, 32'h1);
        rd_chk(REG_STAT, 32'h2, 1'b0);
        apb(1'b1, 8'h18, 32'h1);
        chk({31'h0, err}, 32'h1);
        rd_chk(8'h18, 32'h0, 1'b1);
    endtask

    task s_prop;
        ana_a <= code(4);
        apb(1'b1, REG_GAIN, 32'h3);
        apb(1'b1, REG_CMD, {16'h0, 8'hfb, 8'h0a});
        wait_pwr(1'b0, 8'sd18, 3 * P);
        wait_pwr(1'b1, -8'sd15, 3 * P);
        ana_a <= code(10);
        wait_pwr(1'b0, 8'sd0, 3 * P);
        rd_chk(REG_MEAS, 32'h0000_000a, 1'b0);
        rd_chk(REG_PWR, 32'h0000_f100, 1'b0);
        // Lowest sensor code is full reverse, clipped to the symmetric range
        ana_b <= 8'h00;
        rd_chk(REG_MEAS, 32'h0000_810a, 1'b0);
        ana_b <= 8'h80;
    endtask

    task s_sat;
        apb(1'b1, REG_GAIN, 32'd100);
        ana_a <= code(0);
        wait_pwr(1'b0, 8'sd127, 3 * P);
        wait_pwr(1'b1, -8'sd127, 3 * P);
    endtask

    // Steady error gives no derivative; a step gives one period of boost
    task s_deriv;
        apb(1'b1, REG_GAIN, 32'h0002_0000);
        wait_pwr(1'b0, 8'sd0, 3 * P);
        ana_a <= code(-10);
        wait_pwr(1'b0, 8'sd20, 2 * P + 5);
        wait_pwr(1'b0, 8'sd0, P + 5);
    endtask

    task s_modes;
        apb(1'b1, REG_GAIN, 32'h1);
        apb(1'b1, REG_CMD, {16'h0, 8'h04, 8'h0a});
        ana_a <= code(0);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, REG_CTRL, 32'(m));
            wait_pwr(1'b0, (m == 2) ? 8'sd14 : 8'sd10, 3 * P);
            wait_pwr(1'b1, (m == 2) ? 8'sd6 : 8'sd4, 3 * P);
        end
    endtask

    // Encoder feedback, then a locked shaft at high power must halt for good
    task s_enc;
        int n;
        apb(1'b1, REG_CMD, {16'h0, 8'h04, 8'h3c});
        apb(1'b1, REG_CTRL, 32'h5);
        wait_pwr(1'b0, 8'sd40, 4 * P);
        // Split mode: B leaves the encoder and runs on its analog position
        apb(1'b1, REG_CTRL, 32'h7);
        wait_pwr(1'b1, 8'sd4, 3 * P);
        repeat (3 * P) @(posedge clk);
        chk({31'h0, halt}, 32'h0);
        stall <= 1'b1;
        n = 0;
        while (halt !== 1'b1 && n < 3 * P) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, halt}, 32'h1);
        if (halt !== 1'b1)
            close_out();
        wait_pwr(1'b0, 8'sd0, 3);
        stall <= 1'b0;
        repeat (2 * P) @(posedge clk);
        rd_chk(REG_STAT, 32'h3, 1'b0);
        chk({24'h0, pa}, 32'h0);
        // Next reset comes up without the encoder module
        fitted <= 1'b0;
        do_reset();
    endtask

    // Integral grows by the error each period from a cleared start
    task s_integ;
        apb(1'b1, REG_CMD, 32'h3);
        apb(1'b1, REG_GAIN, 32'h1000);
        wait_pwr(1'b0, 8'sd9, 5 * P);
        wait_pwr(1'b0, 8'sd12, P + 5);
        wait_pwr(1'b0, 8'sd15, P + 5);
    endtask

    // No module fitted: encoder enable is ignored, analog feedback and no stall halt
    task s_nofit;
        rd_chk(REG_STAT, 32'h0, 1'b0);
        apb(1'b1, REG_GAIN, 32'h1);
        apb(1'b1, REG_CTRL, 32'h5);
        apb(1'b1, REG_CMD, 32'h3c);
        wait_pwr(1'b0, 8'sd60, 3 * P);
        stall <= 1'b1;
        repeat (3 * P) @(posedge clk);
        chk({31'h0, halt}, 32'h0);
        stall <= 1'b0;
    endtask

    // Main sequence
    initial begin
        do_reset();
        s_regs();
        s_prop();
        s_sat();
        s_deriv();
        s_modes();
        s_enc();
        s_integ();
        s_nofit();
        close_out();
    end
endmodule
